// *** hw/tsmon_smbus_slave.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// R1: Data falling while clock high starts every transaction.
// R2: Data rising while clock high stops the transaction.
// R3: Data changes only while clock low; stable during clock high.
// R4: All bytes shift most significant bit first, both directions.
// R5: Receiver holds data low on the ninth clock to acknowledge.
// R6: Device is slave only, never makes start, stop or clock.
// R7: Master starts transfers, makes all clocks, ends with stop.
// R8: First byte after start is 7-bit address plus direction bit.
// R9: Master closes each access with a stop.
// R10: Two three-level straps pick one of nine slave addresses.
// R11: Straps are latched only at power-on reset, later ignored.
// R12: Low-power pin at 0 forces standby regardless of others.
// R13: Pin high: halt bit picks normal or standby; one-shot converts once.
// R14: In standby converter stops and both results hold.
// R15: Serial port keeps working fully in standby.
// R16: Normal mode alternates internal and external channels, separate results.
// R17: Alert asserts when any of four thresholds is crossed.
// R18: Results readable any time; thresholds writable over serial port.
// R19: Idle bus lines stay high; no pulling outside a transaction.
// R20: Written data takes effect only at the stop condition; the code also applies it at any start or repeated start.
// R21: Device acknowledges its address byte and each written byte.
// R22: Acknowledge only when the address equals the latched address.
// R23: Eighth address bit 1 means read, 0 means write.
// R24: Master releases data and clocks a ninth pulse for acknowledge.
// R25: Data pin open-drain only; released for other slaves until next start.
// R26: Alert is open-drain active low, released when nothing pending.
module tsmon_smbus_slave
    import tsmon_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYCLES_DEF,
    parameter logic [7:0] MAKER_ID = 8'h5a,  // Arbitrary value
    parameter logic [7:0] REVISION = 8'h01   // Arbitrary value
)
(
    // Core clock and reset
    input logic core_clk,
    input logic reset_n,
    // Link sampling clock
    input logic linkClk,
    // Serial pins
    input logic sclIn,
    input logic sdaIn,
    output logic sdaOut,
    output logic sdaDriveN,
    // Mode and straps
    input logic lowPowerRequestPin,
    input logic [1:0] busIdStrap0,
    input logic [1:0] busIdStrap1,
    // Sensor samples
    input logic [7:0] intSample,
    input logic [7:0] extSample,
    // Alert pin
    output logic alertOut,
    output logic alertDriveN,
    // Status
    output logic standby,
    output logic [6:0] slaveAddr,
    output logic [7:0] intTemp,
    output logic [7:0] extTemp
);
    localparam int CONV_W = $clog2(CONV_CYCLES + 1);
    localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_CYCLES - 1);

    typedef enum logic [2:0] {
        L_IDLE, L_ADDR, L_ADDR_ACK, L_RX, L_RX_ACK, L_TX, L_TX_ACK, L_IGNORE
    } tsmon_lstate_t;

    typedef struct packed {
        logic stbyMeta;
        logic stbySync;
        logic [3:0] strapMeta;
        logic [3:0] strapSync;
        logic [1:0] settle;
        logic addrValid;
        logic [6:0] slaveAddr;
        logic reqMeta;
        logic reqSync;
        logic reqPrev;
        logic ackTgl;
        logic [7:0] rdData;
        logic [7:0] pointer;
        logic [7:0] cfgReg;
        logic [7:0] convRate;
        logic [7:0] intHigh;
        logic [7:0] intLow;
        logic [7:0] extHigh;
        logic [7:0] extLow;
        logic [7:0] intTemp;
        logic [7:0] extTemp;
        logic channel;
        logic oneShot;
        logic [CONV_W-1:0] convCnt;
        logic standby;
        logic [4:0] flags;
        logic alertDriveN;
    } tsmon_core_t;

    typedef struct packed {
        logic rstMeta;
        logic rstSync;
        logic sclMeta;
        logic sclSync;
        logic sclPrev;
        logic sdaMeta;
        logic sdaSync;
        logic sdaPrev;
        logic validMeta;
        logic validSync;
        logic ackMeta;
        logic ackSync;
        logic ackPrev;
        logic [7:0] rdData;
        tsmon_lstate_t state;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic [1:0] byteCnt;
        logic [7:0] cmd;
        logic [7:0] data;
        logic reqTgl;
        logic [1:0] reqKind;
        logic [7:0] reqCmd;
        logic [7:0] reqData;
        logic sdaDriveN;
    } tsmon_link_t;

    tsmon_core_t c;
    tsmon_core_t next_c;
    tsmon_link_t l;
    tsmon_link_t next_l;

    function automatic logic [6:0] tsmonAddr(input logic [1:0] s0, input logic [1:0] s1);
        logic [3:0] hi;
        logic [2:0] base;
        logic [2:0] step;
        hi = (s0 == STRAP_LOW) ? ADDR_HI_LOW : (s0 == STRAP_OPEN) ? ADDR_HI_OPEN : ADDR_HI_HIGH;
        base = (s0 == STRAP_LOW) ? ADDR_LO_LOW : (s0 == STRAP_OPEN) ? ADDR_LO_OPEN : ADDR_LO_HIGH;
        step = (s1 == STRAP_LOW) ? 3'h0 : (s1 == STRAP_OPEN) ? 3'h1 : 3'h2;
        return {hi, 3'(base + step)};
    endfunction

    // Core domain
    always_comb
    begin
        logic halted;
        logic intHi;
        logic intLo;
        logic extHi;
        logic extLo;
        logic shotReq;
        halted = 1'b0;
        shotReq = 1'b0;
        next_c = c;
        // Strap latch once, a few cycles after reset release
        if (!c.addrValid)
        begin
            if (c.settle == SETTLE_DONE)
            begin
                next_c.slaveAddr = tsmonAddr(c.strapSync[1:0], c.strapSync[3:2]); // R10 R11
                next_c.addrValid = 1'b1;
            end
            else
            begin
                next_c.settle = c.settle + 2'h1;
            end
        end
        // Requests from the link, serviced in any mode
        if (c.reqSync != c.reqPrev) // R15
        begin
            next_c.ackTgl = ~c.ackTgl;
            if (l.reqKind == KIND_READ)
            begin
                case (c.pointer) // R18
                    CMD_INT_TEMP: next_c.rdData = c.intTemp;
                    CMD_EXT_TEMP: next_c.rdData = c.extTemp;
                    CMD_STATUS: next_c.rdData = {c.flags, 3'h0};
                    CMD_RD_CONFIG: next_c.rdData = c.cfgReg;
                    CMD_RD_RATE: next_c.rdData = c.convRate;
                    CMD_RD_INT_HIGH: next_c.rdData = c.intHigh;
                    CMD_RD_INT_LOW: next_c.rdData = c.intLow;
                    CMD_RD_EXT_HIGH: next_c.rdData = c.extHigh;
                    CMD_RD_EXT_LOW: next_c.rdData = c.extLow;
                    CMD_MAKER_ID: next_c.rdData = MAKER_ID;
                    CMD_REVISION: next_c.rdData = REVISION;
                    // Stale write pointer reads as error
                    default: next_c.rdData = READ_ERROR;
                endcase
            end
            else
            begin
                next_c.pointer = l.reqCmd;
                if (l.reqKind == KIND_WRITE)
                begin
                    case (l.reqCmd) // R18
                        CMD_WR_CONFIG: next_c.cfgReg = l.reqData & CFG_WRITE_MASK;
                        CMD_WR_RATE: next_c.convRate = l.reqData & RATE_WRITE_MASK;
                        CMD_WR_INT_HIGH: next_c.intHigh = l.reqData;
                        CMD_WR_INT_LOW: next_c.intLow = l.reqData;
                        CMD_WR_EXT_HIGH: next_c.extHigh = l.reqData;
                        CMD_WR_EXT_LOW: next_c.extLow = l.reqData;
                        default: next_c.pointer = l.reqCmd;
                    endcase
                end
                else if (l.reqCmd == CMD_ONE_SHOT)
                begin
                    next_c.oneShot = 1'b1;
                    shotReq = 1'b1;
                    next_c.channel = 1'b0;
                    next_c.convCnt = '0;
                end
            end
        end
        // Operating mode
        halted = !c.stbySync || (c.cfgReg[CFG_STOP_BIT] && !c.oneShot); // R12 R13
        next_c.standby = halted;
        // A one-shot restart beats a coinciding end of conversion
        if (!halted && !shotReq)
        begin
            if (c.convCnt == CONV_LAST)
            begin
                next_c.convCnt = '0;
                next_c.channel = ~c.channel; // R16
                if (c.channel)
                begin
                    next_c.extTemp = extSample;
                    next_c.oneShot = 1'b0; // R13
                end
                else
                begin
                    next_c.intTemp = intSample;
                end
            end
            else
            begin
                next_c.convCnt = c.convCnt + 1'b1;
            end
        end
        // Halted: counter and results simply hold R14
        intHi = $signed(c.intTemp) > $signed(c.intHigh);
        intLo = $signed(c.intTemp) < $signed(c.intLow);
        extHi = $signed(c.extTemp) > $signed(c.extHigh);
        extLo = $signed(c.extTemp) < $signed(c.extLow);
        next_c.flags = {!halted, intHi, intLo, extHi, extLo};
        next_c.alertDriveN = !((intHi || intLo || extHi || extLo)
            && !c.cfgReg[CFG_MASK_BIT]); // R17 R26
        if (!reset_n)
        begin
            next_c = '0;
            next_c.cfgReg = CFG_RESET;
            next_c.convRate = RATE_RESET;
            next_c.intHigh = LIM_HIGH_RESET;
            next_c.extHigh = LIM_HIGH_RESET;
            next_c.intLow = LIM_LOW_RESET;
            next_c.extLow = LIM_LOW_RESET;
            next_c.alertDriveN = 1'b1;
            next_c.standby = 1'b1;
        end
        // Synchronisers run through reset
        next_c.stbyMeta = lowPowerRequestPin;
        next_c.stbySync = c.stbyMeta;
        next_c.strapMeta = {busIdStrap1, busIdStrap0};
        next_c.strapSync = c.strapMeta;
        next_c.reqMeta = l.reqTgl;
        next_c.reqSync = c.reqMeta;
        next_c.reqPrev = c.reqSync;
    end

    always_ff @(posedge core_clk)
    begin
        c <= next_c;
    end

    // Link domain, sampled on a free-running clock
    always_comb
    begin
        logic sclRise;
        logic sclFall;
        logic sclHigh;
        logic startSeen;
        logic stopSeen;
        logic post;
        logic [1:0] postKind;
        sclRise = l.sclSync && !l.sclPrev;
        sclFall = !l.sclSync && l.sclPrev;
        sclHigh = l.sclSync && l.sclPrev;
        startSeen = sclHigh && l.sdaPrev && !l.sdaSync; // R1
        stopSeen = sclHigh && !l.sdaPrev && l.sdaSync; // R2
        post = 1'b0;
        postKind = (l.byteCnt == 2'h1) ? KIND_SEND : KIND_WRITE;
        next_l = l;
        if (l.ackSync != l.ackPrev)
        begin
            next_l.rdData = c.rdData;
        end
        if (startSeen || stopSeen)
        begin
            // Pending command posts at stop, or at any start or repeated start
            post = (l.byteCnt != 2'h0); // R20
            next_l.state = startSeen ? L_ADDR : L_IDLE;
            next_l.cnt = '0;
            next_l.byteCnt = '0;
            next_l.sdaDriveN = 1'b1; // R19
        end
        else
        begin
            case (l.state)
                L_ADDR, L_RX:
                begin
                    if (sclRise)
                    begin
                        next_l.shift = {l.shift[6:0], l.sdaSync}; // R3 R4
                        next_l.cnt = l.cnt + 4'h1;
                    end
                    else if (sclFall && l.cnt == BYTE_BITS)
                    begin
                        next_l.cnt = '0;
                        if (l.state == L_RX)
                        begin
                            next_l.sdaDriveN = 1'b0; // R5 R21
                            next_l.state = L_RX_ACK;
                            if (l.byteCnt == 2'h0)
                            begin
                                next_l.cmd = l.shift;
                            end
                            else if (l.byteCnt == 2'h1)
                            begin
                                next_l.data = l.shift;
                            end
                            if (l.byteCnt != 2'h2)
                            begin
                                next_l.byteCnt = l.byteCnt + 2'h1;
                            end
                        end
                        else if (l.validSync && l.shift[7:1] == c.slaveAddr) // R22
                        begin
                            next_l.sdaDriveN = 1'b0; // R21
                            next_l.state = L_ADDR_ACK;
                            next_l.byteCnt = '0;
                            if (l.shift[0]) // R23
                            begin
                                post = 1'b1;
                                postKind = KIND_READ;
                            end
                        end
                        else
                        begin
                            next_l.state = L_IGNORE; // R25
                        end
                    end
                end
                L_ADDR_ACK:
                begin
                    if (sclFall)
                    begin
                        if (l.shift[0])
                        begin
                            next_l.state = L_TX;
                            next_l.shift = {l.rdData[6:0], 1'b0};
                            next_l.sdaDriveN = l.rdData[7]; // R4
                            next_l.cnt = 4'h1;
                        end
                        else
                        begin
                            next_l.state = L_RX;
                            next_l.sdaDriveN = 1'b1;
                        end
                    end
                end
                L_RX_ACK:
                begin
                    if (sclFall)
                    begin
                        next_l.state = L_RX;
                        next_l.sdaDriveN = 1'b1;
                    end
                end
                L_TX:
                begin
                    if (sclFall)
                    begin
                        if (l.cnt == BYTE_BITS)
                        begin
                            next_l.sdaDriveN = 1'b1; // R24
                            next_l.state = L_TX_ACK;
                        end
                        else
                        begin
                            next_l.sdaDriveN = l.shift[7]; // R3
                            next_l.shift = {l.shift[6:0], 1'b0};
                            next_l.cnt = l.cnt + 4'h1;
                        end
                    end
                end
                L_TX_ACK:
                begin
                    if (sclRise)
                    begin
                        // Master's answer kept in cnt: 0 ack, 8 nack
                        next_l.cnt = l.sdaSync ? BYTE_BITS : 4'h0;
                    end
                    else if (sclFall)
                    begin
                        if (l.cnt == BYTE_BITS)
                        begin
                            next_l.state = L_IGNORE;
                        end
                        else
                        begin
                            next_l.state = L_TX;
                            next_l.shift = {l.rdData[6:0], 1'b0};
                            next_l.sdaDriveN = l.rdData[7];
                            next_l.cnt = 4'h1;
                        end
                    end
                end
                default:
                begin
                    next_l.sdaDriveN = 1'b1; // R6 R25
                end
            endcase
        end
        if (post)
        begin
            next_l.reqTgl = ~l.reqTgl;
            next_l.reqKind = postKind;
            next_l.reqCmd = l.cmd;
            next_l.reqData = l.data;
        end
        if (!l.rstSync)
        begin
            next_l = '0;
            next_l.state = L_IDLE;
            next_l.sdaDriveN = 1'b1;
            next_l.ackPrev = l.ackSync;
            next_l.reqTgl = l.reqTgl;
        end
        next_l.rstMeta = reset_n;
        next_l.rstSync = l.rstMeta;
        next_l.sclMeta = sclIn;
        next_l.sclSync = l.sclMeta;
        next_l.sclPrev = l.sclSync;
        next_l.sdaMeta = sdaIn;
        next_l.sdaSync = l.sdaMeta;
        next_l.sdaPrev = l.sdaSync;
        next_l.validMeta = c.addrValid;
        next_l.validSync = l.validMeta;
        next_l.ackMeta = c.ackTgl;
        next_l.ackSync = l.ackMeta;
        next_l.ackPrev = l.ackSync;
    end

    always_ff @(posedge linkClk)
    begin
        l <= next_l;
    end

    // Open-drain pins only ever pull low
    assign sdaOut = 1'b0 & l.sdaDriveN;
    assign sdaDriveN = l.sdaDriveN;
    assign alertOut = 1'b0 & c.alertDriveN;
    assign alertDriveN = c.alertDriveN;
    assign standby = c.standby;
    assign slaveAddr = c.slaveAddr;
    assign intTemp = c.intTemp;
    assign extTemp = c.extTemp;
endmodule // tsmon_smbus_slave

// *** hw/tsmon_pkg.sv ***
package tsmon_pkg;
    // Command codes
    localparam logic [7:0] CMD_INT_TEMP = 8'h00;
    localparam logic [7:0] CMD_EXT_TEMP = 8'h01;
    localparam logic [7:0] CMD_STATUS = 8'h02;
    localparam logic [7:0] CMD_RD_CONFIG = 8'h03;
    localparam logic [7:0] CMD_RD_RATE = 8'h04;
    localparam logic [7:0] CMD_RD_INT_HIGH = 8'h05;
    localparam logic [7:0] CMD_RD_INT_LOW = 8'h06;
    localparam logic [7:0] CMD_RD_EXT_HIGH = 8'h07;
    localparam logic [7:0] CMD_RD_EXT_LOW = 8'h08;
    localparam logic [7:0] CMD_WR_CONFIG = 8'h09;
    localparam logic [7:0] CMD_WR_RATE = 8'h0a;
    localparam logic [7:0] CMD_WR_INT_HIGH = 8'h0b;
    localparam logic [7:0] CMD_WR_INT_LOW = 8'h0c;
    localparam logic [7:0] CMD_WR_EXT_HIGH = 8'h0d;
    localparam logic [7:0] CMD_WR_EXT_LOW = 8'h0e;
    localparam logic [7:0] CMD_ONE_SHOT = 8'h0f;
    localparam logic [7:0] CMD_MAKER_ID = 8'hfe;
    localparam logic [7:0] CMD_REVISION = 8'hff;
    localparam logic [7:0] READ_ERROR = 8'hff;
    // Configuration fields and reset values
    localparam int CFG_MASK_BIT = 7;
    localparam int CFG_STOP_BIT = 6;
    localparam logic [7:0] CFG_WRITE_MASK = 8'hc0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] RATE_WRITE_MASK = 8'h07;
    localparam logic [7:0] RATE_RESET = 8'h02;
    localparam logic [7:0] LIM_HIGH_RESET = 8'h7f;
    localparam logic [7:0] LIM_LOW_RESET = 8'h80;
    // Status byte bit positions
    localparam int ST_BUSY_BIT = 7;
    localparam int ST_INT_HIGH_BIT = 6;
    localparam int ST_INT_LOW_BIT = 5;
    localparam int ST_EXT_HIGH_BIT = 4;
    localparam int ST_EXT_LOW_BIT = 3;
    // Link request kinds
    localparam logic [1:0] KIND_READ = 2'h0;
    localparam logic [1:0] KIND_SEND = 2'h1;
    localparam logic [1:0] KIND_WRITE = 2'h2;
    // Strap encoding: 00 low, 01 open, 10 high
    localparam logic [1:0] STRAP_LOW = 2'h0;
    localparam logic [1:0] STRAP_OPEN = 2'h1;
    localparam logic [3:0] ADDR_HI_LOW = 4'h3;
    localparam logic [3:0] ADDR_HI_OPEN = 4'h5;
    localparam logic [3:0] ADDR_HI_HIGH = 4'h9;
    localparam logic [2:0] ADDR_LO_LOW = 3'h0;
    localparam logic [2:0] ADDR_LO_OPEN = 3'h1;
    localparam logic [2:0] ADDR_LO_HIGH = 3'h4;
    // Timing
    localparam int CONV_TIME_MS = 83;
    localparam int CORE_CLK_HZ = 20000000;
    localparam int CONV_CYCLES_DEF = CONV_TIME_MS * (CORE_CLK_HZ / 1000);
    localparam logic [1:0] SETTLE_DONE = 2'h3;
    localparam logic [3:0] BYTE_BITS = 4'h8;
endpackage

// *** sim/tsmon_smbus_slave_asserts.sv ***
`timescale 1ns/1ps
module tsmon_smbus_slave_asserts
(
    // Clocks and reset
    input logic core_clk,
    input logic reset_n,
    input logic linkClk,
    // Bus pins
    input logic sclIn,
    input logic sdaIn,
    input logic sdaOut,
    input logic sdaDriveN,
    // Mode, alert and results
    input logic lowPowerRequestPin,
    input logic alertOut,
    input logic standby,
    input logic [6:0] slaveAddr,
    input logic [7:0] intTemp,
    input logic [7:0] extTemp
);
    logic sdaPrev;
    logic sclPrev;
    logic busy;
    // Raw wire view: leads the slave's synchronisers, so never late
    always_ff @(posedge linkClk)
    begin
        sdaPrev <= sdaIn;
        sclPrev <= sclIn;
        if (!reset_n)
            busy <= 1'b0;
        else if (sclIn && sclPrev && sdaPrev && !sdaIn)
            busy <= 1'b1;
        else if (sclIn && sclPrev && !sdaPrev && sdaIn)
            busy <= 1'b0;
    end
    sequence s_ack_fall;
        $fell(sdaDriveN);
    endsequence
    sequence s_ack_hold;
        (!sdaDriveN)[*8];
    endsequence
    a_sda_open_drain: assert property (@(posedge core_clk)
        disable iff (!reset_n) sdaOut == 1'b0)
        else $error("data pin driven high");
    a_alert_open_drain: assert property (@(posedge core_clk)
        disable iff (!reset_n) alertOut == 1'b0)
        else $error("alert pin driven high");
    a_pin_forces_standby: assert property (@(posedge core_clk)
        disable iff (!reset_n) (!lowPowerRequestPin)[*6] |-> standby)
        else $error("no standby with pin low");
    a_standby_freeze: assert property (@(posedge core_clk)
        disable iff (!reset_n) standby && $past(standby) |-> $stable(intTemp) && $stable(extTemp))
        else $error("result changed in standby");
    a_addr_latched: assert property (@(posedge core_clk)
        disable iff (!reset_n) slaveAddr != 7'h00 |=> $stable(slaveAddr))
        else $error("slave address moved");
    a_drive_scl_low: assert property (@(posedge linkClk)
        disable iff (!reset_n) $changed(sdaDriveN) |-> !sclIn)
        else $error("data changed with clock high");
    a_idle_released: assert property (@(posedge linkClk)
        disable iff (!reset_n) !busy |-> sdaDriveN)
        else $error("data pulled on idle bus");
    a_ack_held: assert property (@(posedge linkClk)
        disable iff (!reset_n) s_ack_fall |=> s_ack_hold)
        else $error("low drive too short");
endmodule // tsmon_smbus_slave_asserts

bind tsmon_smbus_slave tsmon_smbus_slave_asserts chk
(
    .core_clk, .reset_n, .linkClk, .sclIn, .sdaIn, .sdaOut, .sdaDriveN,
    .lowPowerRequestPin, .alertOut, .standby, .slaveAddr, .intTemp, .extTemp
);

// *** sim/tsmon_smbus_host.sv ***
`timescale 1ns/1ps
module tsmon_smbus_host
(
    // Timing reference
    input logic core_clk,
    // Slave drive
    input logic sdaOut,
    input logic sdaDriveN,
    // Resolved wires
    output logic sclIn,
    output logic sdaIn
);
    logic sdaHost = 1'b1;
    int q = 10;
    // Pull-up: a released wire reads high
    assign sdaIn = sdaHost & (sdaDriveN | sdaOut);
    initial sclIn = 1'b1;
    task automatic quarter;
        repeat (q) @(posedge core_clk);
        #2;
    endtask
    // Also a repeated start when the clock is low
    task automatic start;
        sdaHost = 1'b1;
        quarter;
        sclIn = 1'b1;
        quarter;
        sdaHost = 1'b0;
        quarter;
        sclIn = 1'b0;
        quarter;
    endtask
    task automatic stop;
        sdaHost = 1'b0;
        quarter;
        sclIn = 1'b1;
        quarter;
        sdaHost = 1'b1;
        quarter;
    endtask
    task automatic bitx(input logic b, output logic r);
        sdaHost = b;
        quarter;
        sclIn = 1'b1;
        quarter;
        r = sdaIn;
        quarter;
        sclIn = 1'b0;
        quarter;
    endtask
    // Eight bits, then a ninth clock; last high releases the wire
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                        output logic ack);
        for (int i = 7; i >= 0; i--)
            bitx(tx[i], rx[i]);
        bitx(last, ack);
    endtask
endmodule // tsmon_smbus_host

// *** sim/tsmon_smbus_slave_tb.sv ***
`timescale 1ns/1ps
module tsmon_smbus_slave_tb
    import tsmon_pkg::*;
;
    logic core_clk = 1'b0;
    logic linkClk = 1'b0;
    logic reset_n = 1'b0;
    logic lowPowerRequestPin = 1'b1;
    logic [1:0] busIdStrap0 = 2'h0;
    logic [1:0] busIdStrap1 = 2'h0;
    logic [7:0] intSample = 8'h3c;
    logic [7:0] extSample = 8'hf6;
    logic sclIn, sdaIn, sdaOut, sdaDriveN, alertOut, alertDriveN, standby, ack;
    logic [6:0] slaveAddr;
    logic [6:0] dev = 7'h4e;
    logic [7:0] intTemp, extTemp, rd;
    logic [6:0] addrTab [9] = '{7'h18, 7'h19, 7'h1a, 7'h29, 7'h2a, 7'h2b, 7'h4c, 7'h4d, 7'h4e};
    int failures = 0;
    int tests_run = 0;
    always #25 core_clk = ~core_clk;
    always #16 linkClk = ~linkClk;
    tsmon_smbus_slave #(.CONV_CYCLES(20)) DUT
    (
        .core_clk, .reset_n, .linkClk, .sclIn, .sdaIn, .sdaOut, .sdaDriveN,
        .lowPowerRequestPin, .busIdStrap0, .busIdStrap1, .intSample, .extSample,
        .alertOut, .alertDriveN, .standby, .slaveAddr, .intTemp, .extTemp
    );
    tsmon_smbus_host host (.core_clk, .sdaOut, .sdaDriveN, .sclIn, .sdaIn);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task automatic wait_for(input int sel, input logic [7:0] exp);
        logic [7:0] v;
        for (int i = 0; i < 3000; i++)
        begin
            v = sel == 0 ? intTemp : sel == 1 ? extTemp : {7'h00, sel == 2 ? alertDriveN : standby};
            if (v === exp)
                return;
            tick(1);
        end
        failures++;
        give_verdict;
    endtask
    // Caller issues the stop, so effects can be probed before it
    task automatic bus_wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                          input logic two, input logic expAck);
        host.start;
        host.xfer({a, 1'b0}, 1'b1, rd, ack);
        check({7'h00, ack}, {7'h00, !expAck});
        host.xfer(c, 1'b1, rd, ack);
        check({7'h00, ack}, {7'h00, !expAck});
        if (two)
        begin
            host.xfer(d, 1'b1, rd, ack);
            check({7'h00, ack}, {7'h00, !expAck});
        end
    endtask
    task automatic bus_rd(input logic [7:0] c, input logic [7:0] exp);
        bus_wr(dev, c, 8'h00, 1'b0, 1'b1);
        host.start;
        host.xfer({dev, 1'b1}, 1'b1, rd, ack);
        check({7'h00, ack}, 8'h00);
        host.xfer(8'hff, 1'b1, rd, ack);
        check(rd, exp);
        host.stop;
    endtask
    task automatic do_reset;
        reset_n = 1'b0;
        tick(10);
        reset_n = 1'b1;
        tick(1);
        check({6'h00, sdaDriveN, alertDriveN}, 8'h03);
        tick(40);
    endtask
    initial
    begin
        for (int i = 0; i < 9; i++)
        begin
            busIdStrap0 = 2'(i / 3);
            busIdStrap1 = 2'(i % 3);
            do_reset;
            check({1'b0, slaveAddr}, {1'b0, addrTab[i]});
        end
        busIdStrap0 = STRAP_LOW;
        busIdStrap1 = STRAP_LOW;
        tick(20);
        check({1'b0, slaveAddr}, {1'b0, dev});
        bus_wr(7'h18, CMD_WR_CONFIG, 8'h40, 1'b1, 1'b0);
        host.stop;
        wait_for(0, 8'h3c);
        wait_for(1, 8'hf6);
        bus_rd(CMD_INT_TEMP, 8'h3c);
        bus_rd(CMD_EXT_TEMP, 8'hf6);
        bus_wr(dev, CMD_WR_EXT_LOW, 8'h00, 1'b1, 1'b1);
        tick(40);
        check({7'h00, alertDriveN}, 8'h01);
        host.stop;
        wait_for(2, 8'h00);
        check({7'h00, alertDriveN}, 8'h00);
        bus_rd(CMD_STATUS, 8'h88);
        bus_rd(CMD_RD_EXT_LOW, 8'h00);
        bus_wr(dev, CMD_WR_CONFIG, 8'h80, 1'b1, 1'b1);
        host.stop;
        wait_for(2, 8'h01);
        check({7'h00, alertDriveN}, 8'h01);
        lowPowerRequestPin = 1'b0;
        wait_for(3, 8'h01);
        intSample = 8'h11;
        tick(100);
        check(intTemp, 8'h3c);
        host.q = 40;
        bus_rd(CMD_INT_TEMP, 8'h3c);
        host.q = 10;
        lowPowerRequestPin = 1'b1;
        wait_for(0, 8'h11);
        check({7'h00, standby}, 8'h00);
        bus_wr(dev, CMD_WR_CONFIG, 8'hc0, 1'b1, 1'b1);
        host.stop;
        wait_for(3, 8'h01);
        intSample = 8'h22;
        extSample = 8'h07;
        tick(100);
        check(intTemp, 8'h11);
        bus_wr(dev, CMD_ONE_SHOT, 8'h00, 1'b0, 1'b1);
        host.stop;
        wait_for(1, 8'h07);
        wait_for(3, 8'h01);
        check(intTemp, 8'h22);
        intSample = 8'h33;
        tick(100);
        check(intTemp, 8'h22);
        bus_wr(dev, CMD_WR_RATE, 8'hff, 1'b1, 1'b1);
        host.stop;
        host.start;
        host.xfer({dev, 1'b1}, 1'b1, rd, ack);
        host.xfer(8'hff, 1'b1, rd, ack);
        check(rd, READ_ERROR);
        host.stop;
        bus_rd(CMD_RD_RATE, RATE_WRITE_MASK);
        give_verdict;
    end
endmodule // tsmon_smbus_slave_tb
